//--- src/ivpm_pkg.sv
// Package for the interrupt vector priority map: slot addresses, source indices, widths and vector layout.
// Assumes a single core clock domain; all users import the whole package.
package ivpm_pkg;
  localparam int IVPM_NSRC = 24;
  localparam int IVPM_IDX_W = 5;
  localparam int IVPM_ADDR_W = 16;
  localparam int IVPM_VEC_W = 24;
  localparam logic [15:0] IVPM_SLOT_RESET = 16'h0004;
  localparam logic [15:0] IVPM_SLOT_SYSEXC = 16'h0008;
  localparam logic [15:0] IVPM_SLOT_RSVD = 16'h000c;
  localparam logic [15:0] IVPM_SLOT_FIRST = 16'h0010;
  localparam logic [15:0] IVPM_SLOT_STEP = 16'h0004;
  localparam logic [15:0] IVPM_SLOT_NONE = 16'h0000;
  // Source indices in fixed vector order, 0 is highest.
  localparam int IVPM_SRC_TMR2 = 0;
  localparam int IVPM_SRC_ADC0 = 7;
  localparam int IVPM_SRC_PAD7 = 8;
  localparam int IVPM_SRC_PAD0 = 15;
  localparam int IVPM_SRC_PWM = 16;
  localparam int IVPM_SRC_PWMF = 19;
  localparam int IVPM_SRC_PC3 = 20;
  localparam int IVPM_SRC_DMA3 = 20;
  localparam int IVPM_SRC_DMA0 = 23;
  // Vector byte positions inside a four-byte entry.
  localparam int IVPM_VB_HI = 1;
  localparam int IVPM_VB_MID = 2;
  localparam int IVPM_VB_LO = 3;
  localparam logic [1:0] IVPM_LVL_NONE = 2'h0;

  typedef struct packed {
    logic valid;
    logic [15:0] slot;
    logic [1:0] level;
  } ivpm_sel_s;

  typedef struct packed {
    logic [7:0] unused;
    logic [7:0] hi;
    logic [7:0] mid;
    logic [7:0] lo;
  } ivpm_entry_s;
endpackage : ivpm_pkg

//--- src/ivpm_port_edge.sv
// Edge detector for one port interrupt bit: synchronises a pin and flags the chosen edge.
// Assumes pin inputs are asynchronous to core_clk.
`timescale 1ns/1ps
module ivpm_port_edge
  import ivpm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic pin_async,
  input wire logic dual_edge,
  input wire logic rise_sel,
  output logic edge_pulse
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  // Two-stage synchroniser and history flop run through reset, so they hold the pin's idle level when it lifts.
  always_ff @(posedge core_clk) begin
    sync1_reg <= pin_async;
    sync2_reg <= sync1_reg;
    prev_reg <= sync2_reg;
  end

  // Reset masks the output; dual-edge mode flags any change; otherwise 1 picks rising and 0 falling.
  always_comb begin
    if (srst) begin
      edge_pulse = 1'b0;
    end else if (dual_edge) begin
      edge_pulse = sync2_reg ^ prev_reg;
    end else if (rise_sel) begin
      edge_pulse = sync2_reg & ~prev_reg;
    end else begin
      edge_pulse = ~sync2_reg & prev_reg;
    end
  end
endmodule : ivpm_port_edge

//--- src/ivpm_top.sv
// Interrupt vector priority map: latches source requests, ranks them and presents the winning slot.
// Assumes peripheral requests are one-cycle pulses on core_clk; pins are asynchronous.
// Contract
// - Reset uses slot 0004H and system exceptions 0008H, both above all peripherals; 000CH is reserved and fixed.
// - Timer 2, Timer 1, Timer 0, UART0 rx, UART0 tx, I2C, SPI, ADC0 rank in that order at 0010H to 002CH.
// - Slot 0030H serves the port A or D bit 7 edge or both comparator edges, chosen by the mux configuration.
// - Slots 0034H to 0048H serve port A or D bits 6 to 1 in descending order on one selectable edge each.
// - Slot 004CH serves the port A or D bit 0 edge or the on-chip debugger interrupt.
// - PWM timer at 0050H, UART1 rx, UART1 tx, then PWM fault at 005CH follow, each with programmable priority.
// - Slots 0060H to 006CH serve port C bits 3 to 0 on both edges or DMA channels 3 to 0.
// - A vector entry leaves byte 0 unused and carries address bits 23:16, 15:8, 7:0 in bytes 1, 2, 3.
// - A higher priority level always wins; fixed order decides only within one level.
// - Edge select 0 means falling and 1 rising; source select 0 means port A and 1 port D.
// - Comparator route 1 feeds slot 7 and debugger route 1 feeds slot 0; 0 keeps the pin.
// - Port C mux 0 selects the DMA channel and 1 the port C pin.
`timescale 1ns/1ps
module ivpm_top
  import ivpm_pkg::*;
#(
  parameter int NSRC = IVPM_NSRC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic reset_req,
  input wire logic sysexc_req,
  input wire logic [7:0] periph_req,
  input wire logic [3:0] late_req,
  input wire logic comparator_async,
  input wire logic debug_req,
  input wire logic [7:0] port_a_async,
  input wire logic [7:0] port_d_async,
  input wire logic [3:0] port_c_async,
  input wire logic [3:0] dma_req,
  input wire logic [7:0] port_irq_edge_select,
  input wire logic [7:0] port_a_or_d_source_select,
  input wire logic comparator_irq_route,
  input wire logic debugger_irq_route,
  input wire logic [3:0] port_c_or_dma_source_select,
  input wire logic [2*NSRC-1:0] src_level,
  input wire logic [NSRC-1:0] ack_clear,
  input wire logic [23:0] vec_addr_in,
  output ivpm_sel_s sel_out,
  output logic [NSRC-1:0] pending_out,
  output ivpm_entry_s entry_out
);
  logic [7:0] pa_edge;
  logic [7:0] pd_edge;
  logic [3:0] pc_edge;
  logic cmp_edge;
  logic [NSRC-1:0] req_now;
  logic [NSRC-1:0] pend_reg;
  logic [NSRC-1:0] pend_next;
  ivpm_sel_s sel_reg;
  ivpm_sel_s sel_next;
  ivpm_entry_s entry_reg;

  // One edge detector per port A, port D and port C bit, plus the comparator.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pad
      ivpm_port_edge u_pa (
        .core_clk(core_clk), .srst(srst), .pin_async(port_a_async[g]),
        .dual_edge(1'b0), .rise_sel(port_irq_edge_select[g]), .edge_pulse(pa_edge[g])
      );
      ivpm_port_edge u_pd (
        .core_clk(core_clk), .srst(srst), .pin_async(port_d_async[g]),
        .dual_edge(1'b0), .rise_sel(port_irq_edge_select[g]), .edge_pulse(pd_edge[g])
      );
    end
    for (g = 0; g < 4; g++) begin : g_pc
      ivpm_port_edge u_pc (
        .core_clk(core_clk), .srst(srst), .pin_async(port_c_async[g]),
        .dual_edge(1'b1), .rise_sel(1'b0), .edge_pulse(pc_edge[g])
      );
    end
  endgenerate

  ivpm_port_edge u_cmp (
    .core_clk(core_clk), .srst(srst), .pin_async(comparator_async),
    .dual_edge(1'b1), .rise_sel(1'b0), .edge_pulse(cmp_edge)
  );

  // Map every source onto its index in fixed vector order.
  always_comb begin
    req_now = '0;
    req_now[IVPM_SRC_ADC0:IVPM_SRC_TMR2] = periph_req;
    for (int b = 0; b < 8; b++) begin
      req_now[IVPM_SRC_PAD0 - b] = port_a_or_d_source_select[b] ? pd_edge[b] : pa_edge[b];
    end
    if (comparator_irq_route) begin
      req_now[IVPM_SRC_PAD7] = cmp_edge;
    end
    if (debugger_irq_route) begin
      req_now[IVPM_SRC_PAD0] = debug_req;
    end
    req_now[IVPM_SRC_PWMF:IVPM_SRC_PWM] = {late_req[0], late_req[1], late_req[2], late_req[3]};
    for (int c = 0; c < 4; c++) begin
      req_now[IVPM_SRC_DMA0 - c] = port_c_or_dma_source_select[c] ? pc_edge[c] : dma_req[c];
    end
  end

  // Pending flags: a new request in the cycle of its acknowledge wins over the clear.
  always_comb begin
    pend_next = (pend_reg & ~ack_clear) | req_now;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // Rank by level first, then by vector order; reset and exceptions always above.
  always_comb begin
    logic [1:0] best_lvl;
    int best_idx;
    best_lvl = IVPM_LVL_NONE;
    best_idx = 0;
    sel_next = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend_reg[i] && src_level[2*i +: 2] != IVPM_LVL_NONE && src_level[2*i +: 2] >= best_lvl) begin
        best_lvl = src_level[2*i +: 2];
        best_idx = i;
      end
    end
    if (reset_req) begin
      sel_next.valid = 1'b1;
      sel_next.slot = IVPM_SLOT_RESET;
      sel_next.level = IVPM_LVL_NONE;
    end else if (sysexc_req) begin
      sel_next.valid = 1'b1;
      sel_next.slot = IVPM_SLOT_SYSEXC;
      sel_next.level = IVPM_LVL_NONE;
    end else if (best_lvl != IVPM_LVL_NONE) begin
      sel_next.valid = 1'b1;
      sel_next.slot = IVPM_SLOT_FIRST + 16'(best_idx) * IVPM_SLOT_STEP;
      sel_next.level = best_lvl;
    end else begin
      sel_next.slot = IVPM_SLOT_NONE;
    end
  end

  // Selection register refreshed on every clock.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sel_reg <= '0;
    end else begin
      sel_reg <= sel_next;
    end
  end

  // Vector entry layout for the fetched service routine address.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      entry_reg <= '0;
    end else begin
      entry_reg.unused <= 8'h00;
      entry_reg.hi <= vec_addr_in[23:16];
      entry_reg.mid <= vec_addr_in[15:8];
      entry_reg.lo <= vec_addr_in[7:0];
    end
  end

  // Registered results drive the outputs directly.
  assign sel_out = sel_reg;
  assign pending_out = pend_reg;
  assign entry_out = entry_reg;

  // Reset and exception slots win on the next clock, and the reserved slot never shows.
  a_reset_slot: assert property (@(posedge core_clk) disable iff (srst)
    reset_req |=> sel_out.valid && sel_out.slot == 16'h0004) else $error("reset slot wrong");
  a_exc_slot: assert property (@(posedge core_clk) disable iff (srst)
    !reset_req && sysexc_req |=> sel_out.slot == 16'h0008) else $error("exception slot wrong");
  a_never_rsvd: assert property (@(posedge core_clk) disable iff (srst)
    sel_out.slot != 16'h000c) else $error("reserved slot chosen");
  // Ranked slots stay inside the peripheral range and always carry a live level.
  a_slot_range: assert property (@(posedge core_clk) disable iff (srst)
    sel_out.valid && sel_out.level != 2'h0 |-> sel_out.slot >= 16'h0010 && sel_out.slot <= 16'h006c)
    else $error("slot out of range");
  a_sel_level: assert property (@(posedge core_clk) disable iff (srst)
    sel_out.valid && sel_out.slot >= 16'h0010 |-> sel_out.level != 2'h0)
    else $error("peripheral slot without level");
  a_idle_none: assert property (@(posedge core_clk) disable iff (srst)
    !reset_req && !sysexc_req && pend_reg == '0 |=> !sel_out.valid) else $error("spurious selection");
  // The level decides first; vector order breaks ties only within one level.
  a_top_wins: assert property (@(posedge core_clk) disable iff (srst)
    !reset_req && !sysexc_req && pend_reg[0] && src_level[1:0] == 2'h3 |=> sel_out.slot == 16'h0010)
    else $error("timer 2 at level 3 lost");
  a_level_max: assert property (@(posedge core_clk) disable iff (srst)
    !reset_req && !sysexc_req && pend_reg[NSRC-1] && src_level[2*NSRC-1 -: 2] == 2'h3
    |=> sel_out.level == 2'h3) else $error("lower level won");
  // Each request lands on its own index, and a new request beats its own clear.
  a_set_wins: assert property (@(posedge core_clk) disable iff (srst)
    req_now[0] && ack_clear[0] |=> pending_out[0]) else $error("request lost on clear");
  a_dma_path: assert property (@(posedge core_clk) disable iff (srst)
    !port_c_or_dma_source_select[0] && dma_req[0] |=> pending_out[IVPM_SRC_DMA0])
    else $error("dma 0 not latched");
  a_adc_path: assert property (@(posedge core_clk) disable iff (srst)
    periph_req[7] |=> pending_out[IVPM_SRC_ADC0]) else $error("adc request not latched");
  a_pwm_timer: assert property (@(posedge core_clk) disable iff (srst)
    late_req[3] |=> pending_out[IVPM_SRC_PWM]) else $error("pwm timer request not latched");
  a_pwm_fault: assert property (@(posedge core_clk) disable iff (srst)
    late_req[0] |=> pending_out[IVPM_SRC_PWMF]) else $error("pwm fault request not latched");
  a_pad_rise: assert property (@(posedge core_clk) disable iff (srst)
    !port_a_or_d_source_select[6] && port_irq_edge_select[6] && pa_edge[6] |=> pending_out[IVPM_SRC_PAD0 - 6])
    else $error("port bit 6 rising edge lost");
  a_pad_fall: assert property (@(posedge core_clk) disable iff (srst)
    port_a_or_d_source_select[1] && !port_irq_edge_select[1] && pd_edge[1] |=> pending_out[IVPM_SRC_PAD0 - 1])
    else $error("port bit 1 falling edge lost");
  a_cmp_route: assert property (@(posedge core_clk) disable iff (srst)
    comparator_irq_route && cmp_edge |=> pending_out[IVPM_SRC_PAD7]) else $error("comparator edge not routed");
  a_dbg_route: assert property (@(posedge core_clk) disable iff (srst)
    debugger_irq_route && debug_req |=> pending_out[IVPM_SRC_PAD0]) else $error("debugger request not routed");
  a_pc_pin: assert property (@(posedge core_clk) disable iff (srst)
    port_c_or_dma_source_select[3] && pc_edge[3] |=> pending_out[IVPM_SRC_PC3])
    else $error("port c pin 3 edge lost");
  // Vector entry bytes follow the fetched address one cycle later.
  a_entry_map: assert property (@(posedge core_clk) disable iff (srst)
    1'b1 |=> entry_out.unused == 8'h00 && entry_out.hi == $past(vec_addr_in[23:16])
    && entry_out.mid == $past(vec_addr_in[15:8]) && entry_out.lo == $past(vec_addr_in[7:0]))
    else $error("vector byte layout wrong");
endmodule : ivpm_top

//--- test/ivpm_cpu_model.sv
// CPU core model: fetches the service address for the presented slot.
// Assumes sel_out comes from ivpm_top on the same core clock.
`timescale 1ns/1ps
module ivpm_cpu_model
  import ivpm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire ivpm_sel_s sel_out,
  output logic [23:0] vec_addr_in
);
  // The program image holds 5ah in the top address byte and the slot below it.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      vec_addr_in <= 24'h000000;
    end else begin
      vec_addr_in <= {8'h5a, sel_out.slot};
    end
  end
endmodule : ivpm_cpu_model

//--- test/test_ivpm_top.sv
// Testbench for the vector priority map: drives requests, pins and routing, checks slot and entry.
// Assumes the CPU model answers each slot with address 5ah followed by the slot.
`timescale 1ns/1ps
module test_ivpm_top
  import ivpm_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic reset_req = 1'b0;
  logic sysexc_req = 1'b0;
  logic [7:0] periph_req = 8'h00;
  logic [3:0] late_req = 4'h0;
  logic comparator_async = 1'b0;
  logic debug_req = 1'b0;
  logic [7:0] port_a_async = 8'h00;
  logic [7:0] port_d_async = 8'h00;
  logic [3:0] port_c_async = 4'h0;
  logic [3:0] dma_req = 4'h0;
  logic [7:0] edge_sel = 8'h00;
  logic [7:0] ad_sel = 8'h00;
  logic cmp_route = 1'b0;
  logic dbg_route = 1'b0;
  logic [3:0] pc_sel = 4'h0;
  logic [47:0] src_level = {24{2'h1}};
  logic [23:0] ack_clear = 24'h000000;
  logic [23:0] pending_out;
  logic [23:0] vec_addr_in;
  ivpm_sel_s sel_out;
  ivpm_entry_s entry_out;
  int err_total = 0;
  int checked = 0;
  // Design under test and the CPU model on its far side.
  ivpm_top ivpm_top_i (.core_clk(core_clk), .srst(srst), .reset_req(reset_req), .sysexc_req(sysexc_req),
    .periph_req(periph_req), .late_req(late_req), .comparator_async(comparator_async), .debug_req(debug_req),
    .port_a_async(port_a_async), .port_d_async(port_d_async), .port_c_async(port_c_async), .dma_req(dma_req),
    .port_irq_edge_select(edge_sel), .port_a_or_d_source_select(ad_sel), .comparator_irq_route(cmp_route),
    .debugger_irq_route(dbg_route), .port_c_or_dma_source_select(pc_sel), .src_level(src_level),
    .ack_clear(ack_clear), .vec_addr_in(vec_addr_in), .sel_out(sel_out), .pending_out(pending_out),
    .entry_out(entry_out));
  ivpm_cpu_model ivpm_cpu_model_i (.core_clk(core_clk), .srst(srst), .sel_out(sel_out),
    .vec_addr_in(vec_addr_in));
  // Waits n rising edges, then steps just past the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  // Compares one result and reports a mismatch at once.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // Checks the presented slot and the vector entry laid out from the fetched address.
  task automatic expect_sel(input logic [15:0] slot);
    cmp({15'h0000, sel_out.valid, sel_out.slot}, {16'h0001, slot});
    cmp(entry_out, {16'h005a, slot});
  endtask : expect_sel
  // Clears one pending source and lets the selection settle.
  task automatic ack(input int i);
    ack_clear[i] = 1'b1;
    tick(1);
    ack_clear = 24'h000000;
    tick(4);
  endtask : ack
  // Sends one-cycle request pulses.
  task automatic pulse(input logic [7:0] p, input logic [3:0] l, input logic [3:0] d, input logic g);
    {periph_req, late_req, dma_req, debug_req} = {p, l, d, g};
    tick(1);
    {periph_req, late_req, dma_req, debug_req} = 17'h00000;
    tick(4);
  endtask : pulse
  task automatic test_exceptions;
    pulse(8'h01, 4'h0, 4'h0, 1'b0);
    {reset_req, sysexc_req} = 2'h3;
    tick(4);
    expect_sel(16'h0004);
    reset_req = 1'b0;
    tick(4);
    expect_sel(16'h0008);
    sysexc_req = 1'b0;
    tick(4);
    expect_sel(16'h0010);
    ack(0);
  endtask : test_exceptions
  task automatic test_fixed_order;
    pulse(8'hff, 4'hf, 4'hf, 1'b0);
    for (int k = 0; k < 24; k++) begin
      if (k < 8 || k > 15) begin
        expect_sel(16'h0010 + 16'(4 * k));
        ack(k);
      end
    end
    cmp({31'h0, sel_out.valid}, 32'h0);
  endtask : test_fixed_order
  task automatic test_levels;
    src_level[15:14] = 2'h3;
    pulse(8'h81, 4'h0, 4'h0, 1'b0);
    expect_sel(16'h002c);
    cmp({30'h0, sel_out.level}, 32'h3);
    ack(7);
    expect_sel(16'h0010);
    src_level[1:0] = 2'h0;
    tick(3);
    cmp({30'h0, sel_out.valid, pending_out[0]}, 32'h1);
    src_level = {24{2'h1}};
    ack(0);
  endtask : test_levels
  // Equal levels fall back to vector order, and a request beats its own clear.
  task automatic test_level_ties;
    src_level[1:0] = 2'h3;
    src_level[47:46] = 2'h3;
    pulse(8'h01, 4'h0, 4'h1, 1'b0);
    expect_sel(16'h0010);
    cmp({30'h0, sel_out.level}, 32'h3);
    src_level[1:0] = 2'h1;
    tick(4);
    expect_sel(16'h006c);
    {periph_req[0], ack_clear[0]} = 2'h3;
    tick(1);
    {periph_req[0], ack_clear[0]} = 2'h0;
    tick(1);
    cmp({31'h0, pending_out[0]}, 32'h1);
    ack(23);
    ack(0);
    cmp({31'h0, sel_out.valid}, 32'h0);
    src_level = {24{2'h1}};
  endtask : test_level_ties
  task automatic test_port_ad;
    edge_sel = 8'h40;
    ad_sel = 8'h02;
    port_d_async[1] = 1'b1;
    port_a_async[1] = 1'b1;
    tick(8);
    port_a_async[1] = 1'b0;
    tick(8);
    cmp({31'h0, sel_out.valid}, 32'h0);
    port_a_async[6] = 1'b1;
    tick(8);
    expect_sel(16'h0034);
    ack(9);
    port_d_async[1] = 1'b0;
    tick(8);
    expect_sel(16'h0048);
    ack(14);
  endtask : test_port_ad
  task automatic test_routes;
    cmp_route = 1'b1;
    dbg_route = 1'b1;
    for (int e = 0; e < 2; e++) begin
      comparator_async = ~comparator_async;
      tick(8);
      expect_sel(16'h0030);
      ack(8);
    end
    pulse(8'h00, 4'h0, 4'h0, 1'b1);
    expect_sel(16'h004c);
    ack(15);
    pc_sel = 4'h8;
    for (int e = 0; e < 2; e++) begin
      port_c_async[3] = ~port_c_async[3];
      tick(8);
      expect_sel(16'h0060);
      ack(20);
    end
  endtask : test_routes
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // Clock of 20 ns period.
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // Main sequence after ten cycles of reset.
  initial begin
    tick(10);
    srst = 1'b0;
    tick(4);
    test_exceptions;
    test_fixed_order;
    test_levels;
    test_level_ties;
    test_port_ad;
    test_routes;
    tally_and_finish;
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #200000;
    err_total++;
    tally_and_finish;
  end
endmodule : test_ivpm_top
